/* logic/phy_control_pin_logic.sv */
// pin control logic: management port, interrupt/wake pin,
// reference clock output, chip reset and strap capture
// assumes: apb and event inputs on pclk, other pins asynchronous to pclk
//
// How it works
// [R1] management data sampled and driven only at management clock edges
// [R2] interrupt conditions enabled and status read in interrupt control register
// [R3] polarity bit selects active-high interrupt output; active low after reset
// [R4] in wake option the pin goes low on a wake-on-lan event
// [R5] interrupt and wake pin always driven to both levels
// [R6] reference clock output driven when the clock enable option is set
// [R7] pulled level on clock output pin latched as indicator style
// [R8] chip reset active low; straps captured on its rising edge
// [R9] board supplies the reference oscillator the logic runs from
// [R10] interrupt pin inactive when nothing enabled pending, again after clearing; in wake option the pin follows the wake status bit, enabled or not
`include "phy_pin_regs.svh"

module phy_control_pin_logic (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  event_in,
  input  wire logic        wake_on_lan_event,
  input  wire logic        mdc_in,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe_n,
  input  wire logic        chip_reset_n_in,
  input  wire logic [2:0]  phy_addr_strap_in,
  input  wire logic        clk125_en_strap_in,
  input  wire logic        clk125_in,
  input  wire logic        ref_clock_out_in,
  output logic             ref_clock_out_out,
  output logic             ref_clock_out_oe_n,
  output logic             wake_event_out,
  output logic             irq
);

  ////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  logic [7:0] pins_s;
  logic       mdc_s;
  logic       mdio_s;
  logic       rst_s;
  logic [2:0] phyad_s;
  logic       clk_strap_s;
  logic       led_strap_s;
  logic       mdc_d_reg;
  logic       rst_d_reg;
  logic       mdc_rise;
  logic       mdc_fall;
  logic       rst_rise;

  pin_sync #(
    .WIDTH(8)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .async_in ({ref_clock_out_in, clk125_en_strap_in, phy_addr_strap_in,
                chip_reset_n_in, mdio_in, mdc_in}),
    .sync_out (pins_s)
  );

  assign mdc_s       = pins_s[0];
  assign mdio_s      = pins_s[1];
  assign rst_s       = pins_s[2];
  assign phyad_s     = pins_s[5:3];
  assign clk_strap_s = pins_s[6];
  assign led_strap_s = pins_s[7];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdc_d_reg <= 1'b0;
      rst_d_reg <= 1'b0;
    end else if (ce) begin
      mdc_d_reg <= mdc_s;
      rst_d_reg <= rst_s;
    end
  end

  // [R1] edges of the management clock
  assign mdc_rise = mdc_s & ~mdc_d_reg;
  assign mdc_fall = ~mdc_s & mdc_d_reg;
  assign rst_rise = rst_s & ~rst_d_reg;

  ////////////////////////////////////////////////////////////
  // strap capture

  logic [4:0] strap_reg;

  // [R8] capture on reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_reg <= `STRAP_RST;
    end else if (ce && rst_rise) begin
      // [R7] indicator style strap
      strap_reg <= {phyad_s, clk_strap_s, led_strap_s};
    end
  end

  ////////////////////////////////////////////////////////////
  // register write port shared by apb and management frames

  logic [7:0]  int_en_reg;
  logic [7:0]  int_stat_reg;
  logic [15:0] phy_ctrl_reg;
  logic [7:0]  apb_idx;
  logic        apb_hit;
  logic        apb_wr;
  logic        md_wr_pend_reg;
  logic [4:0]  md_addr_reg;
  logic [15:0] md_wdata_reg;
  logic        wr_go;
  logic [7:0]  wr_idx;
  logic [15:0] wr_data;
  logic [7:0]  stat_clr;
  logic [7:0]  stat_set;

  function automatic logic [15:0] rd_mux(input logic [7:0] idx);
    case (idx)
      `INT_CTRL_IDX: rd_mux = {int_en_reg, int_stat_reg};
      `PHY_CTRL_IDX: rd_mux = phy_ctrl_reg;
      `STRAP_IDX:    rd_mux = {11'h000, strap_reg};
      default:       rd_mux = 16'h0000;
    endcase
  endfunction

  assign apb_idx = paddr[9:2];
  assign apb_hit = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                   ((apb_idx == `INT_CTRL_IDX) || (apb_idx == `PHY_CTRL_IDX) ||
                    (apb_idx == `STRAP_IDX));
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~apb_hit;
  assign apb_wr  = psel & penable & pwrite & apb_hit;

  // apb wins; a pending frame write waits one cycle
  always_comb begin
    wr_go   = 1'b0;
    wr_idx  = 8'h00;
    wr_data = 16'h0000;
    if (apb_wr) begin
      wr_go   = 1'b1;
      wr_idx  = apb_idx;
      wr_data = pwdata[15:0];
    end else if (md_wr_pend_reg) begin
      wr_go   = 1'b1;
      wr_idx  = {3'h0, md_addr_reg};
      wr_data = md_wdata_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      // refused reads return zero
      prdata <= apb_hit ? {16'h0000, rd_mux(apb_idx)} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////
  // interrupt control and status

  assign stat_set = {wake_on_lan_event, event_in};
  assign stat_clr = (wr_go && wr_idx == `INT_CTRL_IDX) ? wr_data[7:0] : 8'h00;

  // [R2] enables and sticky status, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en_reg   <= `INT_EN_RST;
      int_stat_reg <= `INT_STAT_RST;
    end else if (ce) begin
      if (!rst_s) begin
        int_en_reg   <= `INT_EN_RST;
        int_stat_reg <= `INT_STAT_RST;
      end else begin
        if (wr_go && wr_idx == `INT_CTRL_IDX) begin
          int_en_reg <= wr_data[15:`INT_EN_LSB];
        end
        int_stat_reg <= (int_stat_reg & ~stat_clr) | stat_set;
      end
    end
  end

  // [R3] polarity and option control, clock enable from strap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_ctrl_reg <= `PHY_CTRL_RST;
    end else if (ce) begin
      if (!rst_s) begin
        phy_ctrl_reg <= `PHY_CTRL_RST;
      end else if (rst_rise) begin
        phy_ctrl_reg <= `PHY_CTRL_RST | ({15'h0000, clk_strap_s} << `CLK_EN_BIT);
      end else if (wr_go && wr_idx == `PHY_CTRL_IDX) begin
        phy_ctrl_reg <= wr_data;
      end
    end
  end

  logic int_act;
  assign int_act = |(int_stat_reg & int_en_reg);

  // [R5] push-pull pin, driven both ways
  // [R10] irq inactive unless enabled status pending; in wake option the pin follows the wake status bit, enabled or not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq            <= 1'b0;
      wake_event_out <= 1'b1;
    end else if (ce) begin
      irq <= int_act;
      if (phy_ctrl_reg[`WAKE_SEL_BIT]) begin
        // [R4] low on wake event
        wake_event_out <= ~int_stat_reg[`WAKE_STAT_BIT];
      end else begin
        // [R3] selectable polarity
        wake_event_out <= phy_ctrl_reg[`POL_BIT] ? int_act : ~int_act;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // reference clock output

  // [R6] gated clock; enable bit and chip reset switch the gate at any phase of clk125_in
  // in a real part this gate would be a glitch-free clock cell
  assign ref_clock_out_out  = clk125_in & phy_ctrl_reg[`CLK_EN_BIT] & rst_s;
  // [R7] released during chip reset so the pull level shows
  assign ref_clock_out_oe_n = ~(phy_ctrl_reg[`CLK_EN_BIT] & rst_s);

  ////////////////////////////////////////////////////////////
  // management frame slave

  phy_pin_pkg::mdio_state_type state_reg;
  logic [5:0]  cnt_reg;
  logic [15:0] sh_reg;
  logic [12:0] cmd;
  logic        cmd_ok;

  assign cmd    = {sh_reg[11:0], mdio_s};
  assign cmd_ok = cmd[12] && (cmd[9:5] == {2'h0, strap_reg[4:2]});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= phy_pin_pkg::md_idle;
      cnt_reg        <= 6'h00;
      sh_reg         <= 16'h0000;
      md_addr_reg    <= 5'h00;
      md_wdata_reg   <= 16'h0000;
      md_wr_pend_reg <= 1'b0;
      mdio_out       <= 1'b1;
      mdio_oe_n      <= 1'b1;
    end else if (ce) begin
      if (md_wr_pend_reg && !apb_wr) begin
        md_wr_pend_reg <= 1'b0;
      end
      if (!rst_s) begin
        state_reg <= phy_pin_pkg::md_idle;
        cnt_reg   <= 6'h00;
        mdio_oe_n <= 1'b1;
      end else begin
        case (state_reg)
          phy_pin_pkg::md_idle: begin
            // [R1] sampled on rising edge
            if (mdc_rise) begin
              if (mdio_s) begin
                if (cnt_reg != `PREAMBLE_LEN) begin
                  cnt_reg <= cnt_reg + 6'h01;
                end
              end else if (cnt_reg == `PREAMBLE_LEN) begin
                state_reg <= phy_pin_pkg::md_cmd;
                cnt_reg   <= 6'h00;
              end else begin
                cnt_reg <= 6'h00;
              end
            end
          end
          phy_pin_pkg::md_cmd: begin
            if (mdc_rise) begin
              sh_reg  <= {sh_reg[14:0], mdio_s};
              cnt_reg <= cnt_reg + 6'h01;
              if (cnt_reg == `CMD_LEN - 6'h01) begin
                md_addr_reg <= cmd[4:0];
                cnt_reg     <= 6'h00;
                if (cmd_ok && cmd[11:10] == `OP_READ) begin
                  sh_reg    <= rd_mux({3'h0, cmd[4:0]});
                  state_reg <= phy_pin_pkg::md_rd;
                end else if (cmd_ok && cmd[11:10] == `OP_WRITE) begin
                  state_reg <= phy_pin_pkg::md_ta_wr;
                end else begin
                  state_reg <= phy_pin_pkg::md_idle;
                end
              end
            end
          end
          phy_pin_pkg::md_ta_wr: begin
            if (mdc_rise) begin
              cnt_reg <= cnt_reg + 6'h01;
              if (cnt_reg == `TA_LEN - 6'h01) begin
                cnt_reg   <= 6'h00;
                state_reg <= phy_pin_pkg::md_wr;
              end
            end
          end
          phy_pin_pkg::md_wr: begin
            if (mdc_rise) begin
              sh_reg  <= {sh_reg[14:0], mdio_s};
              cnt_reg <= cnt_reg + 6'h01;
              if (cnt_reg == `DATA_LEN - 6'h01) begin
                md_wdata_reg   <= {sh_reg[14:0], mdio_s};
                md_wr_pend_reg <= 1'b1;
                cnt_reg        <= 6'h00;
                state_reg      <= phy_pin_pkg::md_idle;
              end
            end
          end
          phy_pin_pkg::md_rd: begin
            // [R1] driven on falling edge, sampled by master on rising
            if (mdc_fall) begin
              cnt_reg <= cnt_reg + 6'h01;
              if (cnt_reg == 6'h01) begin
                mdio_out  <= 1'b0;
                mdio_oe_n <= 1'b0;
              end else if (cnt_reg == `RD_LAST) begin
                mdio_out  <= 1'b1;
                mdio_oe_n <= 1'b1;
                cnt_reg   <= 6'h00;
                state_reg <= phy_pin_pkg::md_idle;
              end else if (cnt_reg != 6'h00) begin
                mdio_out <= sh_reg[15];
                sh_reg   <= {sh_reg[14:0], 1'b0};
              end
            end
          end
          default: begin
            state_reg <= phy_pin_pkg::md_idle;
            cnt_reg   <= 6'h00;
            mdio_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

/* logic/phy_pin_regs.svh */
// register indices, field positions, reset values and counts
// assumes: included by bare name from the design files
`ifndef PHY_PIN_REGS_SVH
`define PHY_PIN_REGS_SVH

`define INT_CTRL_IDX  8'h1b
`define PHY_CTRL_IDX  8'h1f
`define STRAP_IDX     8'h20

`define INT_EN_LSB    8
`define WAKE_STAT_BIT 7
`define POL_BIT       14
`define WAKE_SEL_BIT  13
`define CLK_EN_BIT    12

`define INT_EN_RST    8'h00
`define INT_STAT_RST  8'h00
`define PHY_CTRL_RST  16'h0000
`define STRAP_RST     5'h00

`define PREAMBLE_LEN  6'h20
`define CMD_LEN       6'h0d
`define TA_LEN        6'h02
`define DATA_LEN      6'h10
`define RD_LAST       6'h12
`define OP_READ       2'b10
`define OP_WRITE      2'b01

`endif

/* logic/phy_pin_pkg.sv */
// types shared by the pin control logic
// assumes: compiled before every design module
package phy_pin_pkg;
  typedef enum logic [2:0] {
    md_idle,
    md_cmd,
    md_ta_wr,
    md_wr,
    md_rd
  } mdio_state_type;
endpackage

/* logic/pin_sync.sv */
// two-flop synchroniser for a group of asynchronous pins
// assumes: pclk domain, asynchronous active-low reset
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else if (ce) begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule

/* bench/mgmt_station.sv */
// management station model: makes the clock and frames
// assumes: bench resolves the data line with a pull-up
module mgmt_station (
  output logic      mdc,
  output logic      mdio_drive,
  output logic      mdio_en,
  input  wire logic mdio_line
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    mdc = 1'b0;
    mdio_drive = 1'b1;
    mdio_en = 1'b0;
  end

  // clock runs in frames only; sample at rise
  task automatic tick(output logic s);
    #62.5 mdc = 1'b1;
    s = mdio_line;
    #62.5 mdc = 1'b0;
  endtask

  // data moves just after the falling edge
  task automatic put(input logic b);
    logic s;
    mdio_en = 1'b1;
    mdio_drive = b;
    tick(s);
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [16:0] rd);
    logic [13:0] hd;
    logic        s;
    hd = {2'b01, op, phy, rg};
    rd = 17'h1ffff;
    for (int i = 0; i < 32; i++) put(1'b1);
    for (int i = 13; i >= 0; i--) put(hd[i]);
    if (op == 2'b01) begin
      put(1'b1);
      put(1'b0);
      for (int i = 15; i >= 0; i--) put(wd[i]);
    end else begin
      mdio_en = 1'b0;
      tick(s);
      for (int i = 16; i >= 0; i--) tick(rd[i]);
    end
    // released line must not keep showing the last bit
    mdio_en = 1'b0;
    mdio_drive = ~mdio_drive;
  endtask
endmodule

/* bench/phy_control_pin_logic_assertions.sv */
// port checks of the pin control logic
// assumes: bound to phy_control_pin_logic, pclk domain
module phy_pin_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [6:0]  event_in,
  input wire logic        wake_on_lan_event,
  input wire logic        mdc_in,
  input wire logic        mdio_out,
  input wire logic        mdio_oe_n,
  input wire logic        wake_event_out,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("access without ready");
  property p_err; psel && penable && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("misaligned access accepted");
  property p_rd0; psel && penable && !pwrite && pslverr |-> prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("refused read not zero");
  property p_hi0; psel && penable && !pwrite |-> prdata[31:16] == 16'h0; endproperty
  a_hi0: assert property (p_hi0) else $error("upper read bits set");
  property p_mdio;
    !mdio_oe_n && $changed(mdio_out) || $changed(mdio_oe_n) |-> !mdc_in && !$past(mdc_in);
  endproperty
  a_mdio: assert property (p_mdio) else $error("data pin moved off clock fall");
  property p_clr;
    irq && psel && penable && pwrite && paddr == 12'h06c && pwdata[7:0] == 8'hff
      && event_in == 7'h0 && !wake_on_lan_event |-> ##2 !irq;
  endproperty
  a_clr: assert property (p_clr) else $error("irq held after clear");
  property p_cause;
    $rose(irq) |-> $past(wake_on_lan_event, 2) || $past(event_in, 2) != 7'h0
      || $past(pwrite, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("irq without cause");
  property p_pol_rst; $rose(presetn) |-> wake_event_out && !irq; endproperty
  a_pol_rst: assert property (p_pol_rst) else $error("pin active after reset");

  c_err: cover property (psel && penable && pslverr);
  c_irq: cover property ($rose(irq));
  c_mdio: cover property ($fell(mdio_oe_n));
endmodule

bind phy_control_pin_logic phy_pin_checker u_phy_pin_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .event_in(event_in), .wake_on_lan_event(wake_on_lan_event), .mdc_in(mdc_in),
  .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .wake_event_out(wake_event_out),
  .irq(irq));

/* bench/testbench.sv */
// self-checking bench for the pin control logic
// assumes: station model and bound checker compiled
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [6:0]  event_in = 7'h00;
  logic        wake_on_lan = 1'b0;
  logic        chip_rst_n = 1'b0;
  logic [2:0]  phy_strap = 3'h5;
  logic        clk_strap = 1'b1;
  logic        led_pull = 1'b1;
  logic        clk125 = 1'b0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, e, mdc, mdio_drv, mdio_en, mdio_line, mdio_out;
  logic        mdio_oe_n, led_line, ref_out, ref_oe_n, wake_pin, irq;
  logic [16:0] mrd;
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #5 pclk = ~pclk;
  always #4 clk125 = ~clk125;
  assign mdio_line = !mdio_oe_n ? mdio_out : (mdio_en ? mdio_drv : 1'b1);
  assign led_line = ref_oe_n ? led_pull : ref_out;

  phy_control_pin_logic u_phy_control_pin_logic (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_in(event_in), .wake_on_lan_event(wake_on_lan), .mdc_in(mdc),
    .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .chip_reset_n_in(chip_rst_n), .phy_addr_strap_in(phy_strap),
    .clk125_en_strap_in(clk_strap), .clk125_in(clk125), .ref_clock_out_in(led_line),
    .ref_clock_out_out(ref_out), .ref_clock_out_oe_n(ref_oe_n),
    .wake_event_out(wake_pin), .irq(irq));
  mgmt_station u_mgmt_station (.mdc(mdc), .mdio_drive(mdio_drv), .mdio_en(mdio_en),
    .mdio_line(mdio_line));

  task automatic chk(input string nm, input logic [32:0] x, input logic [32:0] got);
    samples_checked++;
    if (got !== x) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, x, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("BAD pready expected 1 seen %b", pready);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk("read", {xe, x}, {e, q});
  endtask

  task automatic pins(input logic xi, input logic xw);
    chk("irq", {32'h0, xi}, {32'h0, irq});
    chk("pin", {32'h0, xw}, {32'h0, wake_pin});
  endtask

  task automatic pulse(input logic [6:0] ev, input logic wk);
    @(posedge pclk);
    event_in <= ev;
    wake_on_lan <= wk;
    @(posedge pclk);
    event_in <= 7'h00;
    wake_on_lan <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #200us;
    error_cnt++;
    test_done;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chip_rst_n <= 1'b1;
    // strap pins move later; capture must not follow them
    repeat (8) @(posedge pclk);
    phy_strap <= 3'h2;
    clk_strap <= 1'b0;
    led_pull <= 1'b0;
    rd(12'h080, 32'h17, 1'b0);
    rd(12'h07c, 32'h1000, 1'b0);
    chk("oe", 33'h0, {32'h0, ref_oe_n});
    pins(1'b0, 1'b1);
    $display("test straps done");
    apb(1'b1, 12'h06c, 32'h8100);
    pulse(7'h02, 1'b0);
    pins(1'b0, 1'b1);
    rd(12'h06c, 32'h8102, 1'b0);
    pulse(7'h01, 1'b0);
    pins(1'b1, 1'b0);
    apb(1'b1, 12'h07c, 32'h5000);
    pins(1'b1, 1'b1);
    apb(1'b1, 12'h06c, 32'h81ff);
    rd(12'h06c, 32'h8100, 1'b0);
    pins(1'b0, 1'b0);
    $display("test irq done");
    apb(1'b1, 12'h07c, 32'h3000);
    pins(1'b0, 1'b1);
    pulse(7'h00, 1'b1);
    pins(1'b1, 1'b0);
    apb(1'b1, 12'h07c, 32'h7000);
    pins(1'b1, 1'b0);
    apb(1'b1, 12'h06c, 32'h8180);
    pins(1'b0, 1'b1);
    $display("test wake done");
    rd(12'h070, 32'h0, 1'b1);
    rd(12'h06d, 32'h0, 1'b1);
    apb(1'b1, 12'h080, 32'h0);
    rd(12'h080, 32'h17, 1'b0);
    apb(1'b1, 12'h07c, 32'h0);
    chk("oe", 33'h1, {32'h0, ref_oe_n});
    apb(1'b1, 12'h07c, 32'h1000);
    // four pclk edges land on both clock phases
    repeat (4) begin
      @(posedge pclk);
      chk("clk", {32'h0, clk125}, {32'h0, ref_out});
    end
    $display("test access done");
    u_mgmt_station.frame(2'b01, 5'h05, 5'h1f, 16'h1234, mrd);
    rd(12'h07c, 32'h1234, 1'b0);
    u_mgmt_station.frame(2'b01, 5'h06, 5'h1f, 16'h0000, mrd);
    rd(12'h07c, 32'h1234, 1'b0);
    u_mgmt_station.frame(2'b10, 5'h05, 5'h1b, 16'h0000, mrd);
    chk("mdio", 33'h08100, {16'h0, mrd});
    $display("test management done");
    test_done;
  end
endmodule
